/* core/ctbf_pkg.sv */
// constants, register map and carrier types of the coarse-tune band finder
package ctbf_pkg;
  // clocks and times
  localparam longint CLK_HZ        = 125000000;
  localparam longint REF_HZ        = 1280000;   // reference clock, 1.28 MHz
  localparam int     REF_DIV       = int'(CLK_HZ / REF_HZ);
  localparam int     REF_DIV_W     = 7;
  localparam int     PRESCALE_W    = 4;         // divide-by-sixteen
  localparam int     GATE_MSB      = 14;        // 16384 reference clocks
  localparam int     RANGE_W       = 15;
  localparam int     NUM_BANDS     = 8;
  localparam int     NUM_SOL       = 11;
  localparam int     NUM_FILT      = 3;
  localparam int     GAIN_W        = 3;
  localparam int     TICK_W        = 24;
  localparam int     TIMER_S       = 10;        // servo window, seconds
  localparam int     RAMP_DELAY_MS = 1000;      // ramp-hold delay, ms
  localparam int     ONESHOT_US    = 1000;      // one-shot widths, us
  localparam longint TIMER_TICKS   = TIMER_S * REF_HZ;
  localparam longint RAMP_TICKS    = (RAMP_DELAY_MS * REF_HZ) / 1000;
  localparam longint ONESHOT_TICKS = (ONESHOT_US * REF_HZ) / 1000000;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] COUNT_OFS  = 12'h008;
  localparam logic [11:0] GATE_OFS   = 12'h00c;

  // control field positions
  localparam int CTRL_SOL_EN    = 0;
  localparam int CTRL_TUNE_DONE = 1;
  localparam int CTRL_CLR_COARSE = 2;   // write-one pulse
  localparam int CTRL_CLR_MUTE  = 3;    // write-one pulse
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // band latch thresholds in divided pulses, ascending frequency
  localparam logic [RANGE_W-1:0] BAND_THR [NUM_BANDS] = '{
    15'h0500, 15'h0780, 15'h0af0, 15'h0fa0,
    15'h15e0, 15'h1f40, 15'h2bc0, 15'h3e80};

  // solenoid map: bit b set means band b+1 needs this capacitor
  localparam logic [NUM_BANDS-1:0] SOL_MAP [NUM_SOL] = '{
    8'h06, 8'h14, 8'hd0, 8'hd8, 8'he0, 8'hc1,
    8'hcb, 8'h82, 8'h1c, 8'h03, 8'h0f};

  // status word as read back
  typedef struct packed {
    logic [15:0]          reserved;
    logic                 ramp_hold;
    logic                 timer_running;
    logic                 coarse_cmd;
    logic                 mute;
    logic                 measuring;
    logic [2:0]           band_code;
    logic [NUM_BANDS-1:0] band_latch;
  } ctbf_status_t;

  // apb request bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ctbf_apb_req_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SHOT1, SEQ_SHOT2} ctbf_seq_t;
endpackage

/* core/ctbf_top.sv */
// coarse-tune band finder: frequency gate, band decode and servo start sequence
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ctbf_top
  import ctbf_pkg::*;
#(
  parameter logic [TICK_W-1:0] TIMER_CNT   = TICK_W'(TIMER_TICKS),
  parameter logic [TICK_W-1:0] RAMP_CNT    = TICK_W'(RAMP_TICKS),
  parameter logic [TICK_W-1:0] SHOT1_CNT   = TICK_W'(ONESHOT_TICKS),
  parameter logic [TICK_W-1:0] SHOT2_CNT   = TICK_W'(ONESHOT_TICKS),
  parameter logic [RANGE_W-1:0] THR [NUM_BANDS] = BAND_THR
) (
  // clock, reset, enable
  input  wire  logic                 pclk,
  input  wire  logic                 presetn,
  input  wire  logic                 ce,
  // apb slave
  input  wire  logic                 psel,
  input  wire  logic                 penable,
  input  wire  logic                 pwrite,
  input  wire  logic [11:0]          paddr,
  input  wire  logic [31:0]          pwdata,
  input  wire  logic [3:0]           pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // drive unit and front panel
  input  wire  logic                 tune_in,
  input  wire  logic                 tune_reset_pulse,
  input  wire  logic                 range_override_switch,
  input  wire  logic [GAIN_W-1:0]    gain_req,
  // band outputs
  output logic [NUM_BANDS-1:0]       band_sel,
  output logic [NUM_FILT-1:0]        filter_sel,
  output logic [NUM_SOL-1:0]         solenoid_switch_gate,
  output logic [2:0]                 band_code,
  output logic [NUM_BANDS-1:0]       coarse_tap_sel,
  output logic [NUM_BANDS-1:0]       load_tap_sel,
  // servo sequence outputs
  output logic                       mute,
  output logic                       coarse_cmd,
  output logic                       coarse_led,
  output logic                       ramp_hold,
  output logic                       timer_running,
  output logic                       servo_relay_en,
  output logic [GAIN_W-1:0]          gain_ctrl
);

  ctbf_apb_req_t        req;
  ctbf_status_t         status;
  ctbf_seq_t            seq;
  logic [1:0]           ctrl;
  logic                 clr_coarse;
  logic                 clr_mute;
  logic [REF_DIV_W-1:0] ref_div;
  logic                 ref_tick;
  logic                 tune_prev;
  logic                 pulse_prev;
  logic                 cmd_rise;
  logic                 cmd_fall;
  logic [PRESCALE_W-1:0] prescale;
  logic                 div_pulse;
  logic                 clk_gate_en;
  logic                 pulse_gate_en;
  logic                 gate_open;
  logic [GATE_MSB:0]    gate_count;
  logic [RANGE_W-1:0]   range_count;
  logic [NUM_BANDS-1:0] band_latch;
  logic [NUM_BANDS-1:0] therm_onehot;
  logic [TICK_W-1:0]    shot_count;
  logic                 shot2_start;
  logic [TICK_W-1:0]    timer_count;
  logic                 ramp_pending;
  logic [TICK_W-1:0]    ramp_count;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic [31:0]          next_rdata;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // zero-wait slave, errors on unmapped offsets
  assign pready  = 1'b1;
  assign addr_ok = (req.addr == CTRL_OFS) || (req.addr == STATUS_OFS) ||
                   (req.addr == COUNT_OFS) || (req.addr == GATE_OFS);
  assign pslverr = req.sel && req.enable && !addr_ok;
  assign wr_en   = ce && req.sel && req.enable && req.write && addr_ok;
  assign rd_en   = ce && req.sel && !req.enable && !req.write;

  // control register; clear bits act as write-one pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= CTRL_RESET;
      clr_coarse <= 1'b0;
      clr_mute   <= 1'b0;
    end else if (ce) begin
      clr_coarse <= 1'b0;
      clr_mute   <= 1'b0;
      if (wr_en && req.addr == CTRL_OFS && pstrb[0]) begin
        ctrl       <= req.wdata[CTRL_TUNE_DONE:CTRL_SOL_EN];
        clr_coarse <= req.wdata[CTRL_CLR_COARSE];
        clr_mute   <= req.wdata[CTRL_CLR_MUTE];
      end
    end
  end

  // status assembly; reserved bits read zero
  always_comb begin
    status               = '0;
    status.band_latch    = band_latch;
    status.band_code     = band_code;
    status.measuring     = clk_gate_en;
    status.mute          = mute;
    status.coarse_cmd    = coarse_cmd;
    status.timer_running = timer_running;
    status.ramp_hold     = ramp_hold;
  end

  // read data is sampled in the setup cycle so it is stable for the access
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (req.addr)
      CTRL_OFS:   next_rdata = {30'h0, ctrl};
      STATUS_OFS: next_rdata = status;
      COUNT_OFS:  next_rdata = {17'h0, range_count};
      GATE_OFS:   next_rdata = {17'h0, gate_count};
      default:    next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_rdata;
    end
  end

  // input edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_prev  <= 1'b0;
      pulse_prev <= 1'b0;
    end else if (ce) begin
      tune_prev  <= tune_in;
      pulse_prev <= tune_reset_pulse;
    end
  end
  assign cmd_rise = tune_reset_pulse && !pulse_prev;
  assign cmd_fall = !tune_reset_pulse && pulse_prev;

  // reference tick, stopped once software reports tuning complete
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div <= '0;
    end else if (ce) begin
      if (ctrl[CTRL_TUNE_DONE] || ref_div == REF_DIV_W'(REF_DIV - 1)) begin
        ref_div <= '0;
      end else begin
        ref_div <= ref_div + 1'b1;
      end
    end
  end
  assign ref_tick = !ctrl[CTRL_TUNE_DONE] && (ref_div == REF_DIV_W'(REF_DIV - 1));

  // divide-by-sixteen prescaler on tuning input rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
    end else if (ce) begin
      if (cmd_rise) begin
        prescale <= '0;
      end else if (tune_in && !tune_prev) begin
        prescale <= prescale + 1'b1;
      end
    end
  end
  assign div_pulse = tune_in && !tune_prev && (prescale == '1);

  // gates and gate-open latch; command wins over a closing count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gate_en   <= 1'b0;
      pulse_gate_en <= 1'b0;
      gate_open     <= 1'b0;
    end else if (ce) begin
      if (cmd_rise) begin
        clk_gate_en   <= 1'b1;
        pulse_gate_en <= 1'b1;
        gate_open     <= 1'b0;
      end else begin
        if (gate_count[GATE_MSB]) begin
          clk_gate_en   <= 1'b0;
          pulse_gate_en <= 1'b0;
        end
        if (div_pulse && pulse_gate_en) begin
          gate_open <= 1'b1;
        end
      end
    end
  end

  // gate-length counter in reference ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_count <= '0;
    end else if (ce) begin
      if (cmd_rise) begin
        gate_count <= '0;
      end else if (ref_tick && clk_gate_en && gate_open && !gate_count[GATE_MSB]) begin
        gate_count <= gate_count + 1'b1;
      end
    end
  end

  // band-range counter, saturating so a very high input cannot wrap to a low band
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_count <= '0;
    end else if (ce) begin
      if (cmd_rise) begin
        range_count <= '0;
      end else if (div_pulse && pulse_gate_en && range_count != '1) begin
        range_count <= range_count + 1'b1;
      end
    end
  end

  // band latches and thermometer-to-one-hot decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANDS; gi++) begin : g_band
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          band_latch[gi] <= 1'b0;
        end else if (ce) begin
          if (cmd_rise) begin
            band_latch[gi] <= 1'b0;
          end else if (range_count >= THR[gi]) begin
            band_latch[gi] <= 1'b1;
          end
        end
      end
      if (gi == NUM_BANDS - 1) begin : g_top
        assign therm_onehot[gi] = band_latch[gi];
      end else begin : g_mid
        assign therm_onehot[gi] = band_latch[gi] ^ band_latch[gi+1];
      end
      // band 1 is the highest frequency
      assign band_sel[gi]       = therm_onehot[NUM_BANDS-1-gi];
      assign coarse_tap_sel[gi] = band_latch[0] && (band_code == 3'(gi));
      assign load_tap_sel[gi]   = band_latch[0] && (band_code == 3'(gi));
    end
  endgenerate

  // band code is the one-hot band index
  always_comb begin
    band_code = 3'h0;
    for (int b = 0; b < NUM_BANDS; b++) begin
      if (band_sel[b]) begin
        band_code = 3'(b);
      end
    end
  end

  // solenoid drives, gated by the software enable
  generate
    for (gi = 0; gi < NUM_SOL; gi++) begin : g_sol
      assign solenoid_switch_gate[gi] = ctrl[CTRL_SOL_EN] && |(SOL_MAP[gi] & band_sel);
    end
  endgenerate

  // filter select: three grid networks covering low, middle and high groups
  assign filter_sel[0] = band_latch[0] && !band_latch[3];
  assign filter_sel[1] = band_latch[3] && !band_latch[6];
  assign filter_sel[2] = band_latch[6];

  // mute latch, set on pulse start; set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute <= 1'b0;
    end else if (ce) begin
      if (cmd_rise) begin
        mute <= 1'b1;
      end else if (clr_mute) begin
        mute <= 1'b0;
      end
    end
  end

  // chained one-shots timed in reference ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq        <= SEQ_IDLE;
      shot_count <= '0;
    end else if (ce) begin
      case (seq)
        SEQ_IDLE: begin
          if (cmd_fall) begin
            seq        <= SEQ_SHOT1;
            shot_count <= '0;
          end
        end
        SEQ_SHOT1: begin
          if (shot_count >= SHOT1_CNT) begin
            seq        <= SEQ_SHOT2;
            shot_count <= '0;
          end else if (ref_tick) begin
            shot_count <= shot_count + 1'b1;
          end
        end
        SEQ_SHOT2: begin
          if (shot_count >= SHOT2_CNT) begin
            seq        <= SEQ_IDLE;
            shot_count <= '0;
          end else if (ref_tick) begin
            shot_count <= shot_count + 1'b1;
          end
        end
        default: begin
          seq        <= SEQ_IDLE;
          shot_count <= '0;
        end
      endcase
    end
  end
  assign shot2_start = (seq == SEQ_SHOT1) && (shot_count >= SHOT1_CNT);

  // coarse and ramp-pending latches; set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coarse_cmd   <= 1'b0;
      ramp_pending <= 1'b0;
    end else if (ce) begin
      if (seq == SEQ_SHOT2) begin
        coarse_cmd   <= 1'b1;
        ramp_pending <= 1'b1;
      end else if (clr_coarse) begin
        coarse_cmd   <= 1'b0;
        ramp_pending <= 1'b0;
      end
    end
  end
  assign coarse_led = coarse_cmd;

  // servo window timer; the limit ends timer_running and with it the servo relay enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count   <= '0;
      timer_running <= 1'b0;
    end else if (ce) begin
      if (shot2_start) begin
        timer_count   <= '0;
        timer_running <= 1'b1;
      end else if (timer_running) begin
        if (timer_count >= TIMER_CNT - 1'b1) begin
          timer_running <= 1'b0;
        end else if (ref_tick) begin
          timer_count <= timer_count + 1'b1;
        end
      end
    end
  end
  assign servo_relay_en = timer_running && !range_override_switch;

  // ramp-hold: high until the delay after ramp-pending sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_count <= '0;
      ramp_hold  <= 1'b1;
    end else if (ce) begin
      if (cmd_rise || !ramp_pending) begin
        ramp_count <= '0;
        ramp_hold  <= 1'b1;
      end else if (ramp_count >= RAMP_CNT) begin
        ramp_hold <= 1'b0;
      end else if (ref_tick) begin
        ramp_count <= ramp_count + 1'b1;
      end
    end
  end

  // maximum servo sensitivity while coarse tuning
  assign gain_ctrl = coarse_cmd ? '0 : gain_req;

endmodule // ctbf_top
`default_nettype wire

/* tb/ctbf_drive_model.sv */
// behavioural drive unit: tuning tone and reset pulse into the band finder
`timescale 1ns/10ps
`default_nettype none
module ctbf_drive_model #(
  parameter int PULSE_CYC = 40
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        rst_n,
  // requests from the bench
  input  wire logic        start,
  input  wire logic [31:0] target,
  // lines into the block, and the rise count back to the bench
  output logic             tune_in,
  output logic             tune_reset_pulse,
  output logic [31:0]      n_rises
);
  int pcnt;

  // pulse width counter, scaled down from tens of milliseconds
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt <= 0;
    end else if (start) begin
      pcnt <= PULSE_CYC;
    end else if (pcnt != 0) begin
      pcnt <= pcnt - 1;
    end
  end
  assign tune_reset_pulse = (pcnt != 0);

  // tone stops low at the requested edge count so counts stay exact
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      tune_in <= 1'b0;
      n_rises <= '0;
    end else if (start) begin
      tune_in <= 1'b0;
      n_rises <= '0;
    end else if (!tune_in && n_rises < target) begin
      tune_in <= 1'b1;
      n_rises <= n_rises + 32'h1;
    end else begin
      tune_in <= 1'b0;
    end
  end
endmodule // ctbf_drive_model
`default_nettype wire

/* tb/ctbf_top_asserts.sv */
// port-level assertion checker for the coarse-tune band finder
`timescale 1ns/10ps
`default_nettype none
module ctbf_top_asserts
  import ctbf_pkg::*;
(
  // clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // inputs watched
  input wire logic                 tune_reset_pulse,
  input wire logic                 range_override_switch,
  // outputs watched
  input wire logic [NUM_BANDS-1:0] band_sel,
  input wire logic [NUM_FILT-1:0]  filter_sel,
  input wire logic [NUM_SOL-1:0]   solenoid_switch_gate,
  input wire logic [2:0]           band_code,
  input wire logic [NUM_BANDS-1:0] coarse_tap_sel,
  input wire logic [NUM_BANDS-1:0] load_tap_sel,
  input wire logic                 mute,
  input wire logic                 coarse_cmd,
  input wire logic                 coarse_led,
  input wire logic                 ramp_hold,
  input wire logic                 timer_running,
  input wire logic                 servo_relay_en,
  input wire logic [GAIN_W-1:0]    gain_ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MUTE:
    assert property ($rose(tune_reset_pulse) |-> ##[1:3] mute) else $error("mute late");
  AST_RELAY:
    assert property (servo_relay_en == (timer_running && !range_override_switch))
      else $error("relay enable wrong");
  AST_LED:
    assert property (coarse_led == coarse_cmd) else $error("coarse indicator wrong");
  AST_GAIN:
    assert property (coarse_cmd |-> gain_ctrl == '0) else $error("gain not forced");
  AST_ONEHOT:
    assert property ($onehot0(band_sel) && $onehot0(filter_sel)) else $error("not one-hot");
  AST_CODE:
    assert property (band_sel != '0 |-> band_sel[band_code]) else $error("band code wrong");
  AST_TAP:
    assert property (band_sel != '0 |-> coarse_tap_sel == (8'h01 << band_code)
      && load_tap_sel == coarse_tap_sel) else $error("tap select wrong");
  AST_IDLE:
    assert property (band_sel == '0 |-> filter_sel == '0 && solenoid_switch_gate == '0)
      else $error("output without band");
  AST_TIMER:
    assert property ($rose(coarse_cmd) |-> ##[0:2] timer_running) else $error("timer idle");
  AST_RAMP:
    assert property ($rose(coarse_cmd) |-> ramp_hold [*8]) else $error("ramp hold early");
endmodule // ctbf_top_asserts
`default_nettype wire

/* tb/tb_coarse_tune_band_finder.sv */
// self-checking bench for the coarse-tune band finder
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module tb_coarse_tune_band_finder
  import ctbf_pkg::*;
;
  localparam int SHOT = 3;
  localparam int RAMP = 20;
  localparam int TMR  = 50;
  // stimulus
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, q, target = '0, rnd = 32'h15b70f92;
  logic [3:0] pstrb = 4'hf;
  logic range_override_switch = 0, start = 0, e;
  logic [GAIN_W-1:0] gain_req = '0;
  // observed
  logic pready, pslverr, tune_in, tune_reset_pulse, mute, coarse_cmd, coarse_led;
  logic ramp_hold, timer_running, servo_relay_en;
  logic [31:0] prdata, n_rises;
  logic [NUM_BANDS-1:0] band_sel, coarse_tap_sel, load_tap_sel;
  logic [NUM_FILT-1:0] filter_sel;
  logic [NUM_SOL-1:0] solenoid_switch_gate;
  logic [2:0] band_code;
  logic [GAIN_W-1:0] gain_ctrl;
  int num_errors = 0, n_tests = 0, cyc = 0, t0;

  ctbf_top #(.TIMER_CNT(TICK_W'(TMR)), .RAMP_CNT(TICK_W'(RAMP)),
    .SHOT1_CNT(TICK_W'(SHOT)), .SHOT2_CNT(TICK_W'(SHOT))) ctbf_top_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tune_in(tune_in),
    .tune_reset_pulse(tune_reset_pulse), .range_override_switch(range_override_switch),
    .gain_req(gain_req), .band_sel(band_sel), .filter_sel(filter_sel),
    .solenoid_switch_gate(solenoid_switch_gate), .band_code(band_code),
    .coarse_tap_sel(coarse_tap_sel), .load_tap_sel(load_tap_sel), .mute(mute),
    .coarse_cmd(coarse_cmd), .coarse_led(coarse_led), .ramp_hold(ramp_hold),
    .timer_running(timer_running), .servo_relay_en(servo_relay_en), .gain_ctrl(gain_ctrl));

  ctbf_drive_model #(.PULSE_CYC(40)) ctbf_drive_model_inst (
    .pclk(pclk), .rst_n(presetn), .start(start), .target(target), .tune_in(tune_in),
    .tune_reset_pulse(tune_reset_pulse), .n_rises(n_rises));

  always #4 pclk = ~pclk;

  // cycle count doubles as the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // stimulus source, one shift per call
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic fire();
    @(posedge pclk) start <= 1'b1;
    @(posedge pclk) start <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // expected band outputs for a count of set latches
  task automatic chk_bands(input int nl, input logic sol);
    logic [7:0] b;
    logic [10:0] s;
    b = (nl == 0) ? 8'h00 : 8'h01 << (8 - nl);
    foreach (s[i]) s[i] = sol && ((SOL_MAP[i] & b) != 0);
    `CHK("band", b, band_sel)
    if (nl != 0) `CHK("code", 3'(8 - nl), band_code)
    `CHK("coarse tap", b, coarse_tap_sel)
    `CHK("load tap", b, load_tap_sel)
    `CHK("filter", {nl >= 7, nl >= 4 && nl < 7, nl >= 1 && nl < 4}, filter_sel)
    `CHK("solenoid", s, solenoid_switch_gate)
  endtask

  // run the tone to an exact edge count, then compare count and bands
  task automatic meas(input int rises);
    int n;
    int nl;
    target <= rises;
    while (n_rises != rises) @(posedge pclk);
    repeat (6) @(posedge pclk);
    apb(0, COUNT_OFS, 0);
    n = rises / 16;
    `CHK("range count", n, q[14:0])
    nl = 0;
    foreach (BAND_THR[i]) if (n >= BAND_THR[i]) nl++;
    chk_bands(nl, 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("ramp hold at reset", 1'b1, ramp_hold)
    apb(0, 12'h010, 0);
    `CHK("unmapped error", 1'b1, e)
    apb(1, CTRL_OFS, 32'h1);
    apb(0, CTRL_OFS, 0);
    `CHK("ctrl readback", 32'h1, q)
    fire();
    `CHK("mute", 1'b1, mute)
    apb(0, STATUS_OFS, 0);
    `CHK("gate enabled", 1'b1, q[11])
    while (tune_reset_pulse === 1'b1) @(posedge pclk);
    t0 = cyc;
    while (coarse_cmd !== 1'b1) @(posedge pclk);
    `CHK("one-shot chain", 1'b1, (cyc - t0) inside {[(SHOT-1)*REF_DIV:(SHOT+1)*REF_DIV]})
    t0 = cyc;
    repeat (3) @(posedge pclk);
    `CHK("timer running", 1'b1, timer_running)
    `CHK("indicator", 1'b1, coarse_led)
    `CHK("relay auto", 1'b1, servo_relay_en)
    range_override_switch <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("relay manual", 1'b0, servo_relay_en)
    range_override_switch <= 1'b0;
    repeat (4) begin
      rnd = lfsr(rnd);
      gain_req <= rnd[2:0] | 3'h1;
      repeat (2) @(posedge pclk);
      `CHK("gain forced", 3'h0, gain_ctrl)
    end
    while (ramp_hold !== 1'b0) @(posedge pclk);
    `CHK("ramp delay", 1'b1, (cyc - t0) inside {[(RAMP-1)*REF_DIV:(RAMP+1)*REF_DIV]})
    while (timer_running !== 1'b0) @(posedge pclk);
    `CHK("window", 1'b1, (cyc - t0) inside {[(TMR-2)*REF_DIV:(TMR+1)*REF_DIV]})
    `CHK("relay off", 1'b0, servo_relay_en)
    apb(1, CTRL_OFS, 32'h5);
    repeat (2) @(posedge pclk);
    `CHK("coarse cleared", 1'b0, coarse_led)
    `CHK("gain passed", gain_req, gain_ctrl)
    apb(0, GATE_OFS, 0);
    `CHK("no count before pulse", 15'h0, q[14:0])
    meas(1279 * 16 + 15);
    meas(1280 * 16);
    apb(0, GATE_OFS, 0);
    `CHK("gate counting", 1'b1, q[14:0] != 0)
    // tuning complete stops the reference tick, so the gate count freezes
    apb(1, CTRL_OFS, 32'h3);
    apb(0, GATE_OFS, 0);
    t0 = int'(q);
    repeat (2 * REF_DIV) @(posedge pclk);
    apb(0, GATE_OFS, 0);
    `CHK("tick stopped", t0, int'(q))
    apb(1, CTRL_OFS, 32'h1);
    meas(int'(BAND_THR[1]) * 16);
    apb(1, CTRL_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk_bands(2, 1'b0);
    fire();
    apb(0, COUNT_OFS, 0);
    `CHK("restart count", 15'h0, q[14:0])
    chk_bands(0, 1'b0);
    give_verdict();
  end
endmodule // tb_coarse_tune_band_finder

bind ctbf_top ctbf_top_asserts ctbf_top_asserts_inst (
  .pclk(pclk), .presetn(presetn), .tune_reset_pulse(tune_reset_pulse),
  .range_override_switch(range_override_switch), .band_sel(band_sel),
  .filter_sel(filter_sel), .solenoid_switch_gate(solenoid_switch_gate),
  .band_code(band_code), .coarse_tap_sel(coarse_tap_sel), .load_tap_sel(load_tap_sel),
  .mute(mute), .coarse_cmd(coarse_cmd), .coarse_led(coarse_led), .ramp_hold(ramp_hold),
  .timer_running(timer_running), .servo_relay_en(servo_relay_en), .gain_ctrl(gain_ctrl));
`default_nettype wire
